/* design/trw_cfg.svh */
`ifndef TRW_CFG_SVH
`define TRW_CFG_SVH
// Register offsets
`define TRW_A_CSC   8'h80
`define TRW_A_SYS   8'ha1
`define TRW_A_WSF   8'haf
`define TRW_A_WES   8'hc7
`define TRW_A_WCTL  8'hc9
// Reset values
`define TRW_RST_REG 8'h00
// Field positions
`define TRW_WCTL_NORST 0
`define TRW_WCTL_P0EN  1
`define TRW_WCTL_PLS   2
`define TRW_SYS_UP     0
`define TRW_SYS_DOWN   1
`define TRW_SYS_TP     2
`define TRW_SYS_IO     3
`define TRW_SYS_L1     5
`define TRW_WSF_PLS    3
`define TRW_CSC_SLO    1
`define TRW_CSC_SHI    2
`define TRW_CSC_CKA    5
`define TRW_CSC_CKB    6
// Timing
`define TRW_CLK_KHZ    200000
`define TRW_HARD_MS    5
`define TRW_HARD_CYC   (`TRW_HARD_MS * `TRW_CLK_KHZ)
`define TRW_PIN_HOLD   4
`define TRW_L2_HOLD    8
`define TRW_L3_HOLD    1
`define TRW_WDT_RC     8
`define TRW_WAKE_FILT  4
`endif

/* design/trw_pkg.sv */
package trw_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } trw_sfr_req_t;

    typedef enum logic [1:0] {
        TRW_NONE = 2'b00,
        TRW_L1   = 2'b01,
        TRW_L2   = 2'b10,
        TRW_L3   = 2'b11
    } trw_lvl_t;

    typedef enum logic [1:0] {
        TRW_RUN   = 2'b00,
        TRW_LIGHT = 2'b01,
        TRW_DEEP  = 2'b10
    } trw_mode_t;
endpackage : trw_pkg

/* design/trw_top.sv */
`timescale 1ns/1ps
`include "trw_cfg.svh"
// Summary of operation
// - Debug reset resets core, interrupts, timers, serial
// - Level 2 resets control registers plus level 3
// - Level 1 resets flags, state, plus level 2
// - Reset domains nest strictly by tier
// - Calibration, RAM and info area never reset
// - Debug reset only while debug select low
// - Level 2 event wakes and resets by default
// - Wake-no-reset bit wakes without reset
// - Resume clears sleep selects and clock flags
// - Supply restoration on rise or after level 1
// - Supply restoration holds reset 8 cycles
// - Pins 3,4 need port0 wake enable
// - Pin levels must last over 4 cycles
// - Edge select picks active wake edge
// - Pin wake sets IO flag, plus pin flag on pins 1,3,4
// - Pin wake resets by default
// - Timer wakes only from light sleep
// - Timer wake sets flag, clears pulse flag
// - Timer wake holds reset 8 cycles
// - Pulse wake needs enables latched at entry
// - Pulse wake sets both flags
// - Pulse wake resets unless wake-no-reset
// - Hard pin low over 5 ms, 4 cycles after
// - Level 1 sets level-1 flag
// - Watchdog reset lasts 8 RC ticks
// - Debug mode masks POR/WDT and sleep
module trw_top #(
    parameter int unsigned HARD_CYC = `TRW_HARD_CYC
) (
    input  wire logic                  core_clk,
    input  wire logic                  arst_n,
    input  wire trw_pkg::trw_sfr_req_t sfr_req,
    output logic [7:0]                 sfr_rdata,
    input  wire logic                  hard_reset_pin_n,
    input  wire logic                  debug_select_pin,
    input  wire logic                  debug_reset_instr,
    input  wire logic                  por_bor_event,
    input  wire logic                  wdt_overflow,
    input  wire logic                  rc_tick,
    input  wire logic                  supply_above_hi,
    input  wire logic                  supply_below_lo,
    input  wire logic [3:0]            wake_pin,
    input  wire logic [3:0]            wake_pin_in_en,
    input  wire logic                  rtc_wake,
    input  wire logic                  energy_pulse,
    input  wire logic [1:0]            pulse_out_enable,
    output logic                       rst_l1_n,
    output logic                       rst_l2_n,
    output logic                       rst_l3_n,
    output logic                       light_sleep,
    output logic                       deep_sleep,
    output logic                       wake_resume,
    output logic [7:0]                 clock_switch_control
);
    localparam int HW = $clog2(HARD_CYC + 2);

    function automatic trw_pkg::trw_lvl_t max_lvl(input trw_pkg::trw_lvl_t a,
                                                  input trw_pkg::trw_lvl_t b);
        if (a == trw_pkg::TRW_NONE) return b;
        if (b == trw_pkg::TRW_NONE) return a;
        return (a < b) ? a : b;
    endfunction : max_lvl

    function automatic logic [3:0] max_cnt(input logic [3:0] a, input logic [3:0] b);
        return (a > b) ? a : b;
    endfunction : max_cnt

    // Reset release synchroniser
    logic [1:0] rsync_q;
    logic       rst_n;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rsync_q <= 2'b00;
        end else begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end
    assign rst_n = rsync_q[1];

    // Hard reset pin: low must outlast the qualification count
    logic [HW-1:0] hp_cnt_q, hp_cnt_d;
    logic          hp_act_q, hp_act_d;
    always_comb begin
        hp_cnt_d = hp_cnt_q;
        hp_act_d = hp_act_q;
        if (hard_reset_pin_n) begin
            hp_cnt_d = '0;
            hp_act_d = 1'b0;
        end else if (hp_cnt_q > HW'(HARD_CYC)) begin
            hp_act_d = 1'b1;
        end else begin
            hp_cnt_d = hp_cnt_q + 1'b1;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hp_cnt_q <= '0;
            hp_act_q <= 1'b0;
        end else begin
            hp_cnt_q <= hp_cnt_d;
            hp_act_q <= hp_act_d;
        end
    end

    trw_pkg::trw_lvl_t  lvl_q, lvl_d;
    trw_pkg::trw_mode_t mode_q, mode_d;
    logic [7:0] csc_q, csc_d, wes_q, wes_d, wctl_q, wctl_d;
    logic [7:0] sys_q, sys_d, wsf_q, wsf_d, rdata_q, rdata_d;
    logic [3:0] pin_edge, pin_hit;
    logic       dbg, sleeping;
    assign dbg      = ~debug_select_pin;
    assign sleeping = (mode_q != trw_pkg::TRW_RUN);

    // Wake pin filters: a new level counts only after it has stood
    // for more than the filter count, so both sides of an edge qualify
    for (genvar i = 0; i < 4; i++) begin : g_pin
        logic [2:0] cnt_q, cnt_d;
        logic       flt_q, flt_d;
        always_comb begin
            cnt_d = cnt_q;
            flt_d = flt_q;
            if (wake_pin[i] == flt_q) begin
                cnt_d = '0;
            end else if (cnt_q == 3'(`TRW_WAKE_FILT)) begin
                flt_d = wake_pin[i];
                cnt_d = '0;
            end else begin
                cnt_d = cnt_q + 3'h1;
            end
        end
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                cnt_q <= '0;
                flt_q <= 1'b0;
            end else begin
                cnt_q <= cnt_d;
                flt_q <= flt_d;
            end
        end
        // Edge select bit 1 picks rising, 0 falling
        assign pin_edge[i] = (flt_d != flt_q) && (flt_d == wes_q[i]);
    end

    // Enables latched at sleep entry
    logic [3:0] en_q, en_d;
    logic       pls_en_q, pls_en_d, sup_low_q, sup_low_d, aft_l1_q, aft_l1_d;
    logic       sup_ev, tmr_ev, pls_ev, l1_ev, l3_ev, l2_any, l2_rst_ev, wake_nr;

    assign pin_hit = pin_edge & en_q & {{2{wctl_q[`TRW_WCTL_P0EN]}}, 2'b11}
                     & {4{sleeping}};
    assign tmr_ev  = rtc_wake && mode_q == trw_pkg::TRW_LIGHT;
    assign pls_ev  = energy_pulse && mode_q == trw_pkg::TRW_LIGHT && pls_en_q;
    // A sleeping part that enters debug mode restores at once
    assign sup_ev  = (lvl_q != trw_pkg::TRW_L1)
                     && ((supply_above_hi && (sup_low_q || aft_l1_q))
                         || (dbg && sleeping));
    assign l1_ev     = hp_act_q || (!dbg && (por_bor_event || wdt_overflow));
    assign l3_ev     = dbg && debug_reset_instr;
    assign l2_any    = sup_ev || (|pin_hit) || tmr_ev || pls_ev;
    assign l2_rst_ev = l2_any && !wctl_q[`TRW_WCTL_NORST];
    assign wake_nr   = l2_any && wctl_q[`TRW_WCTL_NORST] && sleeping;

    // Reset sequencer
    logic [3:0] cnt_q, cnt_d, rcc_q, rcc_d;
    logic [2:0] hard_reset_pin_n_q, hard_reset_pin_n_d;
    always_comb begin
        lvl_d = lvl_q;
        cnt_d = cnt_q;
        rcc_d = rcc_q;
        if (cnt_q != 4'h0) begin
            cnt_d = cnt_q - 4'h1;
        end
        if (rcc_q != 4'h0 && rc_tick) begin
            rcc_d = rcc_q - 4'h1;
        end
        if (cnt_q == 4'h0 && rcc_q == 4'h0 && !hp_act_q) begin
            lvl_d = trw_pkg::TRW_NONE;
        end
        if (l3_ev) begin
            lvl_d = max_lvl(lvl_d, trw_pkg::TRW_L3);
            cnt_d = max_cnt(cnt_d, 4'(`TRW_L3_HOLD - 1));
        end
        if (l2_rst_ev) begin
            lvl_d = max_lvl(lvl_d, trw_pkg::TRW_L2);
            cnt_d = max_cnt(cnt_d, 4'(`TRW_L2_HOLD - 1));
        end
        if (l1_ev) begin
            lvl_d = trw_pkg::TRW_L1;
            cnt_d = max_cnt(cnt_d, 4'(`TRW_PIN_HOLD - 1));
            if (!dbg && wdt_overflow) begin
                rcc_d = max_cnt(rcc_d, 4'(`TRW_WDT_RC));
            end
        end
        // Nested domain resets
        hard_reset_pin_n_d[0] = (lvl_d != trw_pkg::TRW_L1);
        hard_reset_pin_n_d[1] = hard_reset_pin_n_d[0] && (lvl_d != trw_pkg::TRW_L2);
        hard_reset_pin_n_d[2] = (lvl_d == trw_pkg::TRW_NONE);
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_q  <= trw_pkg::TRW_L1;
            cnt_q  <= 4'(`TRW_PIN_HOLD - 1);
            rcc_q  <= 4'h0;
            hard_reset_pin_n_q <= 3'b000;
        end else begin
            lvl_q  <= lvl_d;
            cnt_q  <= cnt_d;
            rcc_q  <= rcc_d;
            hard_reset_pin_n_q <= hard_reset_pin_n_d;
        end
    end

    // Power mode
    logic wres_q, wres_d;
    always_comb begin
        mode_d   = mode_q;
        en_d     = en_q;
        pls_en_d = pls_en_q;
        wres_d   = 1'b0;
        case (mode_q)
            trw_pkg::TRW_RUN: begin
                // No sleep in debug mode
                if (!dbg && lvl_q == trw_pkg::TRW_NONE) begin
                    en_d     = wake_pin_in_en;
                    pls_en_d = (|pulse_out_enable) && wctl_q[`TRW_WCTL_PLS];
                    if (csc_q[`TRW_CSC_SHI]) begin
                        mode_d = trw_pkg::TRW_DEEP;
                    end else if (csc_q[`TRW_CSC_SLO]) begin
                        mode_d = trw_pkg::TRW_LIGHT;
                    end
                end
            end
            trw_pkg::TRW_LIGHT, trw_pkg::TRW_DEEP: begin
                if (l2_any) begin
                    mode_d = trw_pkg::TRW_RUN;
                    wres_d = wake_nr;
                end
            end
            default: begin
                mode_d = trw_pkg::TRW_RUN;
            end
        endcase
        if (lvl_q == trw_pkg::TRW_L1 || lvl_q == trw_pkg::TRW_L2) begin
            mode_d = trw_pkg::TRW_RUN;
        end
        if (l1_ev || l3_ev) begin
            wres_d = 1'b0;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q   <= trw_pkg::TRW_RUN;
            en_q     <= 4'h0;
            pls_en_q <= 1'b0;
            wres_q   <= 1'b0;
        end else begin
            mode_q   <= mode_d;
            en_q     <= en_d;
            pls_en_q <= pls_en_d;
            wres_q   <= wres_d;
        end
    end

    // Registers and supply tracking. Calibration, timing, RAM and
    // info area live elsewhere and see none of these resets.
    always_comb begin
        csc_d     = csc_q;
        wes_d     = wes_q;
        wctl_d    = wctl_q;
        sys_d     = sys_q;
        wsf_d     = wsf_q;
        rdata_d   = rdata_q;
        sup_low_d = sup_low_q || supply_below_lo;
        aft_l1_d  = aft_l1_q;
        if (sup_ev) begin
            sup_low_d = 1'b0;
            aft_l1_d  = 1'b0;
        end
        if (sfr_req.wr) begin
            case (sfr_req.addr)
                `TRW_A_CSC:  csc_d  = sfr_req.wdata;
                `TRW_A_WES:  wes_d  = sfr_req.wdata;
                `TRW_A_WCTL: wctl_d = sfr_req.wdata;
                default: ;
            endcase
        end
        if (wake_nr && !l1_ev && !l3_ev) begin
            csc_d[`TRW_CSC_SHI:`TRW_CSC_SLO] = 2'b00;
            csc_d[`TRW_CSC_CKB:`TRW_CSC_CKA] = 2'b00;
        end
        if (|pin_hit) begin
            sys_d[`TRW_SYS_IO] = 1'b1;
            wsf_d[0] = wsf_q[0] | pin_hit[0];
            wsf_d[1] = wsf_q[1] | pin_hit[2];
            wsf_d[2] = wsf_q[2] | pin_hit[3];
        end
        if (tmr_ev) begin
            sys_d[`TRW_SYS_TP]  = 1'b1;
            wsf_d[`TRW_WSF_PLS] = 1'b0;
        end
        if (pls_ev) begin
            sys_d[`TRW_SYS_TP]  = 1'b1;
            wsf_d[`TRW_WSF_PLS] = 1'b1;
        end
        if (l2_rst_ev || l3_ev) begin
            sys_d[`TRW_SYS_L1] = 1'b0;
        end
        sys_d[`TRW_SYS_UP]   = supply_above_hi;
        sys_d[`TRW_SYS_DOWN] = supply_below_lo;
        if (lvl_q == trw_pkg::TRW_L1 || lvl_q == trw_pkg::TRW_L2) begin
            csc_d  = `TRW_RST_REG;
            wes_d  = `TRW_RST_REG;
            wctl_d = `TRW_RST_REG;
        end
        if (lvl_q == trw_pkg::TRW_L1) begin
            sys_d              = `TRW_RST_REG;
            wsf_d              = `TRW_RST_REG;
            sys_d[`TRW_SYS_L1] = 1'b1;
            aft_l1_d           = 1'b1;
        end
        if (sfr_req.rd) begin
            case (sfr_req.addr)
                `TRW_A_CSC:  rdata_d = csc_q;
                `TRW_A_SYS:  rdata_d = sys_q;
                `TRW_A_WSF:  rdata_d = wsf_q;
                `TRW_A_WES:  rdata_d = wes_q;
                `TRW_A_WCTL: rdata_d = wctl_q;
                default:     rdata_d = 8'h00;
            endcase
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            csc_q     <= `TRW_RST_REG;
            wes_q     <= `TRW_RST_REG;
            wctl_q    <= `TRW_RST_REG;
            sys_q     <= `TRW_RST_REG;
            wsf_q     <= `TRW_RST_REG;
            rdata_q   <= 8'h00;
            sup_low_q <= 1'b0;
            aft_l1_q  <= 1'b0;
        end else begin
            csc_q     <= csc_d;
            wes_q     <= wes_d;
            wctl_q    <= wctl_d;
            sys_q     <= sys_d;
            wsf_q     <= wsf_d;
            rdata_q   <= rdata_d;
            sup_low_q <= sup_low_d;
            aft_l1_q  <= aft_l1_d;
        end
    end

    assign sfr_rdata            = rdata_q;
    assign rst_l1_n             = hard_reset_pin_n_q[0];
    assign rst_l2_n             = hard_reset_pin_n_q[1];
    assign rst_l3_n             = hard_reset_pin_n_q[2];
    assign light_sleep          = mode_q[0];
    assign deep_sleep           = mode_q[1];
    assign wake_resume          = wres_q;
    assign clock_switch_control = csc_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_l2_start;
        lvl_q == trw_pkg::TRW_NONE && l2_rst_ev && !l1_ev && !l3_ev;
    endsequence
    sequence s_wdt_start;
        lvl_q == trw_pkg::TRW_NONE && wdt_overflow && !dbg;
    endsequence

    a_l3_nest: assert property (lvl_q == trw_pkg::TRW_L3 |-> rst_l1_n && rst_l2_n && !rst_l3_n)
        else $error("Level 3 reset scope wrong");
    a_l1_scope: assert property (!rst_l1_n |-> !rst_l2_n && !rst_l3_n)
        else $error("Level 1 reset does not cover lower tiers");
    a_l2_scope: assert property (!rst_l2_n |-> !rst_l3_n)
        else $error("Level 2 reset does not cover level 3");
    a_l2_hold: assert property (s_l2_start |=> (!rst_l2_n)[*8])
        else $error("Level 2 reset shorter than 8 cycles");
    a_wdt_hold: assert property (s_wdt_start |=> (!rst_l1_n)[*8])
        else $error("Watchdog reset shorter than 8 cycles");
    a_l1_flag: assert property (lvl_q == trw_pkg::TRW_L1 ##1 1'b1 |-> sys_q[`TRW_SYS_L1])
        else $error("Level 1 flag not set");
    a_norst_wake: assert property (wake_nr && !l1_ev && !l3_ev && lvl_q == trw_pkg::TRW_NONE
        |=> rst_l2_n && wake_resume && csc_q[2:1] == 2'b00 && csc_q[6:5] == 2'b00)
        else $error("Wake without reset misbehaved");
    a_dbg_nosleep: assert property (dbg && !sleeping |=> !sleeping)
        else $error("Sleep entered in debug mode");
    a_pulse_flag: assert property (pls_ev && lvl_q == trw_pkg::TRW_NONE
        |=> sys_q[`TRW_SYS_TP] && wsf_q[`TRW_WSF_PLS])
        else $error("Pulse wake flags not set");
    a_timer_flag: assert property (tmr_ev && !pls_ev && lvl_q == trw_pkg::TRW_NONE
        |=> sys_q[`TRW_SYS_TP] && !wsf_q[`TRW_WSF_PLS])
        else $error("Timer wake flags wrong");
endmodule : trw_top

/* test/test_tiered_reset_wakeup_manager.sv */
`timescale 1ns/1ps
`include "trw_cfg.svh"
module test_tiered_reset_wakeup_manager;
    logic                  core_clk;
    logic                  arst_n;
    trw_pkg::trw_sfr_req_t req;
    logic [7:0]            sfr_rdata;
    logic                  hard_n;
    logic                  dbg_sel;
    logic [4:0]            ev;
    logic                  rc_tick;
    logic                  above;
    logic                  below;
    logic [3:0]            pin;
    logic [1:0]            pulse_en;
    logic                  rst_l1_n;
    logic                  rst_l2_n;
    logic                  rst_l3_n;
    logic                  light;
    logic                  deep;
    logic                  resume;
    logic [7:0]            csc;
    logic [2:0]            rs;
    logic [2:0]            lo_seen;
    logic                  resume_seen;
    logic                  clr;
    logic [3:0]            in_en;
    int                    n_fail;
    int                    comparisons;
    int                    cyc;
    int                    n;

    assign rs = {rst_l1_n, rst_l2_n, rst_l3_n};

    trw_top #(.HARD_CYC(20)) DUT (
        .core_clk(core_clk), .arst_n(arst_n), .sfr_req(req), .sfr_rdata(sfr_rdata),
        .hard_reset_pin_n(hard_n), .debug_select_pin(dbg_sel), .debug_reset_instr(ev[2]),
        .por_bor_event(ev[4]), .wdt_overflow(ev[3]), .rc_tick(rc_tick),
        .supply_above_hi(above), .supply_below_lo(below), .wake_pin(pin),
        .wake_pin_in_en(in_en), .rtc_wake(ev[0]), .energy_pulse(ev[1]),
        .pulse_out_enable(pulse_en), .rst_l1_n(rst_l1_n), .rst_l2_n(rst_l2_n),
        .rst_l3_n(rst_l3_n), .light_sleep(light), .deep_sleep(deep),
        .wake_resume(resume), .clock_switch_control(csc)
    );

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // RC clock strobe every fourth cycle, free running
    always @(negedge core_clk) begin
        rc_tick <= (cyc % 4 == 0);
    end

    // Whole run needs under two thousand cycles. Low phases are gathered
    // on the rising edge, so a clear request set at a falling edge never races them
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        lo_seen <= clr ? 3'b000 : (lo_seen | ~rs);
        resume_seen <= clr ? 1'b0 : (resume_seen | (resume === 1'b1));
        if (cyc == 6000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk) req = {1'b1, 1'b0, a, d};
        @(negedge core_clk) req = '0;
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk) req = {1'b0, 1'b1, a, 8'h00};
        @(negedge core_clk) req = '0;
        @(negedge core_clk);
        chk(sfr_rdata, e);
    endtask : rdc

    task automatic strobe(input int k);
        @(negedge core_clk) ev[k] = 1'b1;
        @(negedge core_clk) ev[k] = 1'b0;
    endtask : strobe

    task automatic sleep(input logic [7:0] v);
        wr(`TRW_A_CSC, v);
        repeat (2) @(negedge core_clk);
        clr_seen();
    endtask : sleep

    // Clears the low-phase and resume records at the next rising edge
    task automatic clr_seen;
        clr = 1'b1;
        @(negedge core_clk);
        clr = 1'b0;
    endtask : clr_seen

    // Waits a bounded time for the low phase, then counts its cycles
    task automatic meas(input int b, output int len);
        int w;
        len = 0;
        w = 0;
        while (rs[b] !== 1'b0 && w < 60) begin
            @(negedge core_clk);
            w++;
        end
        while (rs[b] === 1'b0 && len < 200) begin
            @(negedge core_clk);
            len++;
        end
    endtask : meas

    task automatic t_reset;
        arst_n = 1'b0;
        repeat (4) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (30) @(negedge core_clk);
        chk(rs, 3'h7);
        rdc(`TRW_A_SYS, 8'h20);
        wr(`TRW_A_SYS, 8'hff);
        rdc(`TRW_A_SYS, 8'h20);
        rdc(`TRW_A_WSF, 8'h00);
        rdc(`TRW_A_WCTL, 8'h00);
        rdc(`TRW_A_WES, 8'h00);
        wr(8'h55, 8'h5a);
        rdc(8'h55, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_pin;
        sleep(8'h02);
        chk(light, 1'b1);
        pin[0] = 1'b0;
        repeat (4) @(negedge core_clk);
        pin[0] = 1'b1;
        repeat (6) @(negedge core_clk);
        chk({light, lo_seen[1]}, 2'b10);
        pin[0] = 1'b0;
        meas(1, n);
        chk(n, 8);
        chk(lo_seen[2], 1'b0);
        chk(light, 1'b0);
        rdc(`TRW_A_SYS, 8'h08);
        rdc(`TRW_A_WSF, 8'h01);
        rdc(`TRW_A_CSC, 8'h00);
        pin[0] = 1'b1;
        repeat (10) @(negedge core_clk);
        $display("test pin wake done");
    endtask : t_pin

    task automatic t_port0;
        in_en = 4'h7;
        sleep(8'h02);
        pin[2] = 1'b0;
        repeat (20) @(negedge core_clk);
        chk({light, lo_seen[1]}, 2'b10);
        pin[2] = 1'b1;
        repeat (10) @(negedge core_clk);
        wr(`TRW_A_WCTL, 8'h02);
        pin[3] = 1'b0;
        repeat (10) @(negedge core_clk);
        chk({light, lo_seen[1]}, 2'b10);
        pin[2] = 1'b0;
        meas(1, n);
        chk(n, 8);
        rdc(`TRW_A_WSF, 8'h03);
        rdc(`TRW_A_WCTL, 8'h00);
        pin[2] = 1'b1;
        pin[3] = 1'b1;
        in_en = 4'hf;
        repeat (10) @(negedge core_clk);
        $display("test port0 enable done");
    endtask : t_port0

    task automatic t_edge;
        wr(`TRW_A_WES, 8'h01);
        sleep(8'h02);
        pin[0] = 1'b0;
        repeat (15) @(negedge core_clk);
        chk({light, lo_seen[1]}, 2'b10);
        pin[0] = 1'b1;
        meas(1, n);
        chk(n, 8);
        rdc(`TRW_A_WES, 8'h00);
        $display("test edge select done");
    endtask : t_edge

    task automatic t_pulse;
        pulse_en = 2'b01;
        wr(`TRW_A_WCTL, 8'h04);
        sleep(8'h02);
        strobe(1);
        meas(1, n);
        chk(n, 8);
        rdc(`TRW_A_WSF, 8'h0b);
        rdc(`TRW_A_SYS, 8'h0c);
        $display("test pulse wake done");
    endtask : t_pulse

    task automatic t_nores;
        wr(`TRW_A_WCTL, 8'h01);
        sleep(8'h63);
        strobe(1);
        repeat (3) @(negedge core_clk);
        chk(light, 1'b1);
        strobe(0);
        repeat (5) @(negedge core_clk);
        chk({resume_seen, lo_seen}, 4'h8);
        chk(light, 1'b0);
        chk(csc, 8'h01);
        rdc(`TRW_A_CSC, 8'h01);
        rdc(`TRW_A_WCTL, 8'h01);
        rdc(`TRW_A_WSF, 8'h03);
        rdc(`TRW_A_SYS, 8'h0c);
        wr(`TRW_A_WCTL, 8'h00);
        sleep(8'h02);
        strobe(0);
        meas(1, n);
        chk(n, 8);
        $display("test wake without reset done");
    endtask : t_nores

    task automatic t_deep;
        sleep(8'h04);
        chk(deep, 1'b1);
        strobe(0);
        repeat (10) @(negedge core_clk);
        chk({deep, lo_seen[1]}, 2'b10);
        below = 1'b1;
        above = 1'b0;
        repeat (5) @(negedge core_clk);
        below = 1'b0;
        above = 1'b1;
        meas(1, n);
        chk(n, 8);
        chk(deep, 1'b0);
        rdc(`TRW_A_SYS, 8'h0d);
        $display("test deep sleep and supply done");
    endtask : t_deep

    task automatic t_debug;
        clr_seen();
        strobe(2);
        repeat (5) @(negedge core_clk);
        chk(lo_seen, 3'h0);
        dbg_sel = 1'b0;
        repeat (3) @(negedge core_clk);
        strobe(2);
        meas(0, n);
        chk(n, 1);
        chk(lo_seen[2:1], 2'b00);
        strobe(3);
        strobe(4);
        wr(`TRW_A_CSC, 8'h02);
        repeat (12) @(negedge core_clk);
        chk({lo_seen[2], light}, 2'b00);
        wr(`TRW_A_CSC, 8'h00);
        dbg_sel = 1'b1;
        repeat (5) @(negedge core_clk);
        $display("test debug done");
    endtask : t_debug

    task automatic t_hard;
        above = 1'b0;
        below = 1'b1;
        wr(`TRW_A_WCTL, 8'h06);
        hard_n = 1'b0;
        repeat (25) @(negedge core_clk);
        chk(rst_l1_n, 1'b0);
        hard_n = 1'b1;
        n = 0;
        while (rst_l1_n === 1'b0 && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        chk(n >= 4 && n <= 6, 1'b1);
        repeat (20) @(negedge core_clk);
        rdc(`TRW_A_SYS, 8'h22);
        rdc(`TRW_A_WSF, 8'h00);
        rdc(`TRW_A_WCTL, 8'h00);
        $display("test hard reset done");
    endtask : t_hard

    task automatic t_wdt;
        strobe(3);
        meas(2, n);
        chk(n >= 28 && n <= 40, 1'b1);
        rdc(`TRW_A_SYS, 8'h22);
        above = 1'b1;
        below = 1'b0;
        meas(1, n);
        chk(n, 8);
        strobe(4);
        meas(2, n);
        chk(n, 4);
        meas(1, n);
        chk(n, 8);
        rdc(`TRW_A_SYS, 8'h01);
        $display("test watchdog done");
    endtask : t_wdt

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    initial begin
        n_fail = 0;
        comparisons = 0;
        arst_n = 1'b0;
        req = '0;
        hard_n = 1'b1;
        dbg_sel = 1'b1;
        ev = 5'h00;
        above = 1'b0;
        below = 1'b0;
        pin = 4'hf;
        pulse_en = 2'b00;
        in_en = 4'hf;
        clr = 1'b0;
        t_reset();
        t_pin();
        t_port0();
        t_edge();
        t_pulse();
        t_nores();
        t_deep();
        t_debug();
        t_hard();
        t_wdt();
        end_of_test();
    end
endmodule : test_tiered_reset_wakeup_manager
